// ===== rtl/ifr_readout_top.sv
// Frame readout and operating-mode control of a global-shutter sensor.
// Assumes control inputs are on clk; adc_data and the link side run on link_clk.
`timescale 1ns/1ps
`default_nettype none
`include "ifr_consts.svh"
module ifr_readout_top #(
  parameter int PW = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic reset_pin_n,
  input wire logic soft_reset_req,
  input wire logic output_enable_n,
  input wire logic trigger_in,
  input wire logic trig_mode,
  input wire logic serial_sel,
  input wire logic three_lanes,
  input wire logic ctx_sel,
  input wire logic [15:0] ctx0_exposure,
  input wire logic [15:0] ctx1_exposure,
  input wire logic [1:0] ctx0_again,
  input wire logic [1:0] ctx1_again,
  input wire logic [8:0] ctx0_dgain,
  input wire logic [8:0] ctx1_dgain,
  input wire logic [10:0] ctx0_width,
  input wire logic [10:0] ctx1_width,
  input wire logic [10:0] ctx0_height,
  input wire logic [10:0] ctx1_height,
  input wire logic [9:0] hblank_clks,
  input wire logic [9:0] vblank_clks,
  input wire logic mirror_h,
  input wire logic mirror_v,
  input wire logic row_skip,
  input wire logic col_skip,
  input wire logic bin_en,
  input wire logic [2:0] test_pattern,
  input wire logic [PW-1:0] solid_value,
  input wire logic ae_enable,
  input wire logic [PW-1:0] ae_luma,
  input wire logic [PW-1:0] ae_target,
  input wire logic [PW-1:0] adc_data,
  output logic [PW-1:0] dout,
  output logic frame_valid,
  output logic line_valid,
  output logic pixel_clock_out,
  output logic out_oe,
  output logic [10:0] col_addr,
  output logic [10:0] row_addr,
  output logic [1:0] analog_gain,
  output logic flash,
  output logic [2:0] lane_en,
  output logic [15:0] frame_count,
  output logic [15:0] exposure_used
);
  function automatic logic [10:0] clamp_dim(input logic [10:0] v, input logic [10:0] lim);
    clamp_dim = (v > lim) ? lim : v;
  endfunction

  // Mirrored readout counts down from one past the window, using a spare column or row.
  function automatic logic [10:0] map_addr(input logic [10:0] base, input logic [10:0] size,
                                           input logic [10:0] idx, input logic mir);
    map_addr = mir ? 11'(base + size - idx) : 11'(base + idx);
  endfunction

  // ---------------- Control clock domain ----------------
  logic [7:0] rst_cnt;
  logic [7:0] unit_cnt;
  logic pin_rst_n_s, trig_s, trig_d, done_s, done_d, start_tgl;
  logic [15:0] exp_left, ae_exp;
  logic [1:0] ae_gain;
  logic [10:0] sh_w, sh_h;
  logic [8:0] sh_dg;
  ifr_pkg::ifr_ctl_e st;
  ifr_pkg::ifr_ctl_e next_st;

  wire full_rst = rst | (rst_cnt != 8'h00);

  ifr_sync #(.INIT(1'b1)) u_rst_pin (.clk(clk), .rst(rst), .d(reset_pin_n), .q(pin_rst_n_s));
  ifr_sync #(.INIT(1'b0)) u_trig (.clk(clk), .rst(full_rst), .d(trigger_in), .q(trig_s));

  // Every reset source is stretched so that the link side, on its slow clock, sees it too.
  always_ff @(posedge clk) begin
    if (rst) begin
      rst_cnt <= `IFR_RST_HOLD_CYC;
    end else if (soft_reset_req | ~pin_rst_n_s) begin
      rst_cnt <= `IFR_RST_HOLD_CYC;
    end else if (rst_cnt != 8'h00) begin
      rst_cnt <= rst_cnt - 8'h01;
    end
  end

  wire [15:0] sel_exp = ctx_sel ? ctx1_exposure : ctx0_exposure;
  wire [1:0] sel_again = ctx_sel ? ctx1_again : ctx0_again;
  wire [8:0] sel_dg_raw = ctx_sel ? ctx1_dgain : ctx0_dgain;
  wire [8:0] sel_dg = (sel_dg_raw > `IFR_DGAIN_MAX) ? `IFR_DGAIN_MAX : sel_dg_raw;
  wire [10:0] sel_w = clamp_dim(ctx_sel ? ctx1_width : ctx0_width, `IFR_FMT_W);
  wire [10:0] sel_h = clamp_dim(ctx_sel ? ctx1_height : ctx0_height, `IFR_FMT_H);
  wire [15:0] eff_exp = ae_enable ? ae_exp : sel_exp;
  wire [1:0] eff_again = ae_enable ? ae_gain : sel_again;

  // Trigger mode is honoured only with the parallel output.
  wire trig_ok = trig_mode & ~serial_sel;
  wire trig_rise = trig_s & ~trig_d;
  wire done_ev = done_s ^ done_d;
  wire latch = (st == ifr_pkg::ST_IDLE & ~trig_ok) | (st == ifr_pkg::ST_WAIT_TRIG & trig_rise);
  wire exp_fin = (st == ifr_pkg::ST_EXPOSE) & (unit_cnt == 8'h00) & (exp_left == 16'h0000);
  wire frame_end = (st == ifr_pkg::ST_READOUT) & done_ev;

  always_comb begin
    next_st = st;
    unique case (st)
      ifr_pkg::ST_IDLE: next_st = trig_ok ? ifr_pkg::ST_WAIT_TRIG : ifr_pkg::ST_EXPOSE;
      ifr_pkg::ST_WAIT_TRIG: begin
        if (!trig_ok) begin
          next_st = ifr_pkg::ST_IDLE;
        end else if (trig_rise) begin
          next_st = ifr_pkg::ST_EXPOSE;
        end
      end
      ifr_pkg::ST_EXPOSE: next_st = exp_fin ? ifr_pkg::ST_READOUT : ifr_pkg::ST_EXPOSE;
      ifr_pkg::ST_READOUT: next_st = done_ev ? ifr_pkg::ST_IDLE : ifr_pkg::ST_READOUT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (full_rst) begin
      st <= ifr_pkg::ST_IDLE;
      {trig_d, done_d, start_tgl, flash, lane_en, analog_gain} <= '0;
      {frame_count, exp_left, exposure_used, unit_cnt} <= '0;
      sh_w <= `IFR_FMT_W;
      sh_h <= `IFR_FMT_H;
      sh_dg <= `IFR_DGAIN_ONE;
    end else begin
      st <= next_st;
      trig_d <= trig_s;
      done_d <= done_s;
      flash <= (next_st == ifr_pkg::ST_EXPOSE);
      lane_en <= serial_sel ? (three_lanes ? `IFR_LANES_3 : `IFR_LANES_2) : `IFR_LANES_OFF;
      if (latch) begin
        exp_left <= eff_exp;
        unit_cnt <= `IFR_EXP_UNIT_M1;
        exposure_used <= eff_exp;
        analog_gain <= eff_again;
        sh_w <= sel_w;
        sh_h <= sel_h;
        sh_dg <= sel_dg;
      end else if (st == ifr_pkg::ST_EXPOSE && unit_cnt == 8'h00 && exp_left != 16'h0000) begin
        unit_cnt <= `IFR_EXP_UNIT_M1;
        exp_left <= exp_left - 16'h0001;
      end else if (st == ifr_pkg::ST_EXPOSE && unit_cnt != 8'h00) begin
        unit_cnt <= unit_cnt - 8'h01;
      end
      if (exp_fin) begin
        start_tgl <= ~start_tgl;
      end
      if (frame_end) begin
        frame_count <= frame_count + 16'h0001;
      end
    end
  end

  wire [16:0] ae_up = 17'({1'b0, ae_exp} + {5'h00, ae_exp[15:4]} + 17'h00001);
  wire [15:0] ae_dn = 16'(ae_exp - {4'h0, ae_exp[15:4]});
  wire ae_dark = ae_luma < ae_target;

  // Gain is raised only once exposure has run out of range, to keep noise low.
  always_ff @(posedge clk) begin
    if (full_rst) begin
      ae_exp <= 16'h0000;
      ae_gain <= 2'h0;
    end else if (!ae_enable) begin
      ae_exp <= sel_exp;
      ae_gain <= sel_again;
    end else if (frame_end && frame_count[0]) begin
      if (ae_dark && ae_up[16]) begin
        ae_exp <= 16'hffff;
        ae_gain <= (ae_gain == `IFR_AGAIN_MAX) ? ae_gain : 2'(ae_gain + 2'h1);
      end else if (ae_dark) begin
        ae_exp <= ae_up[15:0];
      end else if (ae_gain != 2'h0) begin
        ae_gain <= 2'(ae_gain - 2'h1);
      end else begin
        ae_exp <= ae_dn;
      end
    end
  end

  // ---------------- Link clock domain ----------------
  // Window and mode settings are quasi-static: they only change at frame start,
  // well before the start toggle reaches this domain.
  logic lrst, st_l, st_l_d, oe_n_l, start_pend, done_tgl, ph;
  logic [10:0] row_i, col_i, p_col, p_row;
  logic [9:0] cnt;
  logic p_lv, p_fv, p_drow, p_dcol;
  logic [PW-1:0] hold, blk, rn, pix;
  ifr_pkg::ifr_link_e lst;

  ifr_sync #(.INIT(1'b1)) u_lrst (.clk(link_clk), .rst(1'b0), .d(full_rst), .q(lrst));
  ifr_sync #(.INIT(1'b0)) u_start (.clk(link_clk), .rst(lrst), .d(start_tgl), .q(st_l));
  ifr_sync #(.INIT(1'b1)) u_oe (.clk(link_clk), .rst(lrst), .d(output_enable_n), .q(oe_n_l));
  ifr_sync #(.INIT(1'b0)) u_done (.clk(clk), .rst(full_rst), .d(done_tgl), .q(done_s));

  wire step = ~ph;
  wire [10:0] h_eff = row_skip ? {1'b0, sh_h[10:1]} : sh_h;
  wire [10:0] c_eff = col_skip ? {1'b0, sh_w[10:1]} : sh_w;
  wire [10:0] rows_tot = 11'(`IFR_DARK_ROWS + h_eff);
  wire act_row = row_i >= `IFR_DARK_ROWS;
  wire [10:0] r_idx = 11'(row_i - `IFR_DARK_ROWS);
  wire [10:0] ry = row_skip ? {r_idx[9:0], 1'b0} : r_idx;
  wire [10:0] cx = col_skip ? {col_i[9:0], 1'b0} : col_i;
  // Windows are centred on the optical centre; the default lands on (112,44).
  wire [10:0] x_base = 11'(`IFR_ACT_X0 + `IFR_OPT_CX + 11'd1 - {1'b0, sh_w[10:1]});
  wire [10:0] y_base = 11'(`IFR_ACT_Y0 + `IFR_OPT_CY + 11'd1 - {1'b0, sh_h[10:1]});
  wire [10:0] cur_row = act_row ? map_addr(y_base, sh_h, ry, mirror_v)
                                : 11'(`IFR_DARK_ROW0 + row_i);
  wire [10:0] cur_col = (lst == ifr_pkg::LK_DARKCOL) ? 11'(`IFR_DARK_COL0 + col_i)
                                                     : map_addr(x_base, sh_w, cx, mirror_h);
  wire [PW-1:0] raw = bin_en ? PW'(({1'b0, hold} + {1'b0, adc_data}) >> 1) : adc_data;
  wire take = step & (lst == ifr_pkg::LK_IDLE) & start_pend;

  ifr_pix_path #(.PW(PW)) u_path (
    .raw(raw),
    .offset(rn),
    .dgain(sh_dg),
    .pattern(test_pattern),
    .solid(solid_value),
    .col(p_col),
    .row(p_row),
    .pix(pix)
  );

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      st_l_d <= 1'b0;
      start_pend <= 1'b0;
      ph <= 1'b0;
      pixel_clock_out <= 1'b0;
      out_oe <= 1'b0;
    end else begin
      st_l_d <= st_l;
      start_pend <= (st_l ^ st_l_d) | (start_pend & ~take);
      ph <= ~ph;
      pixel_clock_out <= ph;
      out_oe <= ~oe_n_l;
    end
  end

  // Addresses go out one step ahead; adc_data returns on the following step.
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      {p_lv, p_fv, p_drow, p_dcol} <= 4'h0;
      {p_col, p_row, col_addr, row_addr} <= 44'h0;
      {dout, hold, blk, rn} <= '0;
      line_valid <= 1'b0;
      frame_valid <= 1'b0;
    end else if (step) begin
      col_addr <= cur_col;
      row_addr <= cur_row;
      p_lv <= (lst == ifr_pkg::LK_ROW) & act_row & (~bin_en | col_i[0]);
      p_fv <= act_row & (lst != ifr_pkg::LK_IDLE) & (lst != ifr_pkg::LK_VBLANK);
      p_drow <= (lst == ifr_pkg::LK_ROW) & ~act_row;
      p_dcol <= lst == ifr_pkg::LK_DARKCOL;
      p_col <= col_i;
      p_row <= r_idx;
      hold <= adc_data;
      dout <= p_lv ? pix : '0;
      line_valid <= p_lv;
      frame_valid <= p_fv;
      if (p_drow) begin
        blk <= PW'(blk - (blk >> 4) + (adc_data >> 4));
      end
      if (p_dcol && act_row) begin
        rn <= PW'(rn - (rn >> 4) + (adc_data >> 4));
      end else if (!act_row) begin
        rn <= blk;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      lst <= ifr_pkg::LK_IDLE;
      row_i <= 11'h000;
      col_i <= 11'h000;
      cnt <= 10'h000;
      done_tgl <= 1'b0;
    end else if (step) begin
      unique case (lst)
        ifr_pkg::LK_IDLE: begin
          if (take) begin
            row_i <= 11'h000;
            col_i <= 11'h000;
            lst <= ifr_pkg::LK_ROW;
          end
        end
        ifr_pkg::LK_ROW: begin
          col_i <= (col_i == 11'(c_eff - 11'd1)) ? 11'h000 : 11'(col_i + 11'd1);
          if (col_i == 11'(c_eff - 11'd1)) begin
            lst <= ifr_pkg::LK_DARKCOL;
          end
        end
        ifr_pkg::LK_DARKCOL: begin
          col_i <= 11'(col_i + 11'd1);
          if (col_i == 11'(`IFR_DARK_COLS - 11'd1)) begin
            col_i <= 11'h000;
            cnt <= 10'h000;
            lst <= ifr_pkg::LK_HBLANK;
          end
        end
        ifr_pkg::LK_HBLANK: begin
          cnt <= 10'(cnt + 10'd1);
          if (cnt >= hblank_clks) begin
            cnt <= 10'h000;
            row_i <= 11'(row_i + 11'd1);
            lst <= (row_i == 11'(rows_tot - 11'd1)) ? ifr_pkg::LK_VBLANK : ifr_pkg::LK_ROW;
          end
        end
        ifr_pkg::LK_VBLANK: begin
          cnt <= 10'(cnt + 10'd1);
          if (cnt >= vblank_clks) begin
            done_tgl <= ~done_tgl;
            lst <= ifr_pkg::LK_IDLE;
          end
        end
        default: lst <= ifr_pkg::LK_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== rtl/ifr_consts.svh
// Constants of the frame readout and operating-mode control block.
// Assumes a 200 MHz control clock and a separate pixel-side link clock.
`ifndef IFR_CONSTS_SVH
`define IFR_CONSTS_SVH

`define IFR_CLK_PS 5000
`define IFR_RST_HOLD_NS 800
`define IFR_RST_HOLD_CYC 8'((`IFR_RST_HOLD_NS * 1000 + `IFR_CLK_PS - 1) / `IFR_CLK_PS)
`define IFR_EXP_UNIT_NS 1000
`define IFR_EXP_UNIT_M1 8'((`IFR_EXP_UNIT_NS * 1000) / `IFR_CLK_PS - 1)

`define IFR_ARRAY_COLS 11'd1412
`define IFR_ARRAY_ROWS 11'd1028
`define IFR_ACT_COLS 11'd1288
`define IFR_ACT_ROWS 11'd972
`define IFR_FMT_W 11'd1280
`define IFR_FMT_H 11'd960
`define IFR_ACT_X0 11'd108
`define IFR_ACT_Y0 11'd38
`define IFR_OPT_CX 11'd643
`define IFR_OPT_CY 11'd485
`define IFR_DARK_COL0 11'd1304
`define IFR_DARK_COLS 11'd64
`define IFR_DARK_ROW0 11'd6
`define IFR_DARK_ROWS 11'd12

`define IFR_AGAIN_MAX 2'h3
`define IFR_DGAIN_MAX 9'h100
`define IFR_DGAIN_ONE 9'h020
`define IFR_LANES_OFF 3'h0
`define IFR_LANES_2 3'h3
`define IFR_LANES_3 3'h7

`define IFR_PAT_OFF 3'h0
`define IFR_PAT_SOLID 3'h1
`define IFR_PAT_BARS 3'h2
`define IFR_PAT_FADE 3'h3
`define IFR_PAT_WALK 3'h4

`endif

// ===== rtl/ifr_pkg.sv
// Types shared by the readout control block.
// Assumes nothing beyond a SystemVerilog compiler.
package ifr_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_TRIG, ST_EXPOSE, ST_READOUT} ifr_ctl_e;
  typedef enum logic [2:0] {LK_IDLE, LK_ROW, LK_DARKCOL, LK_HBLANK, LK_VBLANK} ifr_link_e;
  typedef logic [10:0] ifr_addr_t;
endpackage

// ===== rtl/ifr_sync.sv
// Three-stage synchroniser for a single level.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/1ps
`default_nettype none
module ifr_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic s1;
  logic s2;
  logic s3;

  // The output only moves once the second and third stages agree.
  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q <= INIT;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q <= s2;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/ifr_pix_path.sv
// Pixel data path: offset correction, digital gain and test patterns.
// Assumes inputs are stable for one pixel step; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "ifr_consts.svh"
module ifr_pix_path #(
  parameter int PW = 12
) (
  input wire logic [PW-1:0] raw,
  input wire logic [PW-1:0] offset,
  input wire logic [8:0] dgain,
  input wire logic [2:0] pattern,
  input wire logic [PW-1:0] solid,
  input wire logic [10:0] col,
  input wire logic [10:0] row,
  output logic [PW-1:0] pix
);
  wire [PW-1:0] corr = (raw > offset) ? PW'(raw - offset) : '0;
  wire [PW+8:0] prod = corr * dgain;
  wire [PW+3:0] scaled = prod[PW+8:5];
  // Saturate rather than wrap so bright scenes clip cleanly at full scale.
  wire [PW-1:0] gained = (|scaled[PW+3:PW]) ? '1 : scaled[PW-1:0];
  wire [PW-1:0] bars = PW'({4{col[10:8]}});
  wire [PW-1:0] fade = PW'({row, 2'b00});
  wire [PW-1:0] walk = PW'(1) << col[3:0];

  assign pix = (pattern == `IFR_PAT_SOLID) ? solid :
               (pattern == `IFR_PAT_BARS) ? bars :
               (pattern == `IFR_PAT_FADE) ? fade :
               (pattern == `IFR_PAT_WALK) ? walk : gained;
endmodule
`default_nettype wire

// ===== dv/ifr_readout_props.sv
// Concurrent checks on the ports of the frame readout block.
// Assumes it is bound onto ifr_readout_top; rst quiets both clock domains.
`timescale 1ns/1ps
`default_nettype none
module ifr_readout_props #(
  parameter int PW = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic output_enable_n,
  input wire logic [PW-1:0] dout,
  input wire logic frame_valid,
  input wire logic line_valid,
  input wire logic pixel_clock_out,
  input wire logic out_oe,
  input wire logic [1:0] analog_gain,
  input wire logic flash,
  input wire logic [2:0] lane_en,
  input wire logic [15:0] frame_count,
  input wire logic [15:0] exposure_used
);
  // Six link cycles leave room for the synchroniser and the pad register.
  AST_OE_OFF: assert property (@(posedge link_clk) disable iff (rst)
    output_enable_n [*6] |-> !out_oe) else $error("pads driven while disabled");
  AST_LV_IN_FRAME: assert property (@(posedge link_clk) disable iff (rst)
    line_valid |-> frame_valid) else $error("line valid outside frame");
  AST_DOUT_BLANK: assert property (@(posedge link_clk) disable iff (rst)
    !line_valid |-> dout == {PW{1'b0}}) else $error("data outside line");
  AST_FV_OPENS: assert property (@(posedge link_clk) disable iff (rst)
    $rose(frame_valid) |-> line_valid) else $error("frame opened without line");
  AST_DOUT_HOLD: assert property (@(posedge link_clk) disable iff (rst)
    $rose(pixel_clock_out) |-> $stable(dout) && $stable(line_valid))
    else $error("data moved at pixel clock rise");
  AST_LANES: assert property (@(posedge clk) disable iff (rst)
    lane_en inside {3'h0, 3'h3, 3'h7}) else $error("bad lane set");
  AST_GAIN_BOUNDARY: assert property (@(posedge clk) disable iff (rst)
    !$stable(analog_gain) |-> !frame_valid) else $error("gain moved in frame");
  AST_EXPO_BOUNDARY: assert property (@(posedge clk) disable iff (rst)
    !$stable(exposure_used) |-> !frame_valid) else $error("exposure moved in frame");
  AST_FLASH_MIN: assert property (@(posedge clk) disable iff (rst)
    $rose(flash) |-> flash [*8]) else $error("exposure too short");
  AST_EXPOSE_FIRST: assert property (@(posedge clk) disable iff (rst)
    flash |-> !frame_valid) else $error("exposure overlaps readout");
  AST_COUNT_STEP: assert property (@(posedge clk) disable iff (rst)
    !$stable(frame_count) |-> frame_count == $past(frame_count) + 16'h1 || frame_count == 16'h0)
    else $error("frame count jumped");
  CV_EXPOSE: cover property (@(posedge clk) disable iff (rst) $rose(flash));
  CV_FRAME: cover property (@(posedge link_clk) disable iff (rst) $fell(frame_valid));
  CV_LANES: cover property (@(posedge clk) disable iff (rst) lane_en == 3'h7);
endmodule
bind ifr_readout_top ifr_readout_props #(.PW(PW)) u_props (.clk, .rst, .link_clk,
  .output_enable_n, .dout, .frame_valid, .line_valid, .pixel_clock_out, .out_oe,
  .analog_gain, .flash, .lane_en, .frame_count, .exposure_used);
`default_nettype wire

// ===== dv/ifr_host_rx.sv
// Host receiver model taking the parallel pixel stream.
// Assumes pixels are valid only while pads are driven and both valids are high.
`timescale 1ns/1ps
`default_nettype none
module ifr_host_rx (
  input wire logic pclk,
  input wire logic oe,
  input wire logic fv,
  input wire logic lv,
  input wire logic [11:0] d,
  output logic got,
  output logic [11:0] pix,
  output logic [15:0] lines
);
  logic lv_d = 1'b0;
  initial begin
    got = 1'b0;
    pix = 12'h0;
    lines = 16'h0;
  end
  always @(posedge pclk) begin
    got <= oe && fv && lv;
    if (oe && fv && lv) pix <= d;
    if (lv_d && !lv) lines <= lines + 16'h1;
    lv_d <= lv;
  end
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench of the readout block with the host receiver model.
// Assumes the block, its checker and the receiver are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "ifr_consts.svh"
module tb_top;
  logic clk = 1'b0, rst = 1'b1, link_clk = 1'b0, reset_pin_n = 1'b1, soft_reset_req = 1'b0;
  logic output_enable_n = 1'b0, trigger_in = 1'b0, trig_mode = 1'b0, serial_sel = 1'b0;
  logic three_lanes = 1'b0, ctx_sel = 1'b0, mirror_h = 1'b0, mirror_v = 1'b0;
  logic row_skip = 1'b0, col_skip = 1'b0, bin_en = 1'b0, ae_enable = 1'b0;
  logic [15:0] ctx0_exposure = 16'h0, ctx1_exposure = 16'h1, frame_count, exposure_used;
  logic [15:0] rx_lines;
  logic [1:0] ctx0_again = 2'h0, ctx1_again = 2'h0, analog_gain;
  logic [8:0] ctx0_dgain = 9'h020, ctx1_dgain = 9'h020;
  logic [10:0] ctx0_width = 11'd2, ctx1_width = 11'd2, ctx0_height = 11'd1;
  logic [10:0] ctx1_height = 11'd1, col_addr, row_addr;
  logic [9:0] hblank_clks = 10'h0, vblank_clks = 10'h0;
  logic [2:0] test_pattern = 3'h1, lane_en;
  logic [11:0] solid_value = 12'h0, ae_luma = 12'h0, ae_target = 12'h0, adc_data = 12'h0;
  logic [11:0] dout, rx_pix;
  logic frame_valid, line_valid, pixel_clock_out, out_oe, flash, rx_got;
  int errors = 0, samples_checked = 0;
  logic fv_was = 1'b0;
  logic [11:0] exp_q[$];

  always #2.5 clk = ~clk;
  // Odd offset keeps link edges off the control clock edges.
  initial begin
    #37.3;
    forever #80 link_clk = ~link_clk;
  end
  always @(negedge link_clk) adc_data <= 12'($urandom());

  ifr_readout_top #(.PW(12)) uut (.clk, .rst, .link_clk, .reset_pin_n, .soft_reset_req,
    .output_enable_n, .trigger_in, .trig_mode, .serial_sel, .three_lanes, .ctx_sel,
    .ctx0_exposure, .ctx1_exposure, .ctx0_again, .ctx1_again, .ctx0_dgain, .ctx1_dgain,
    .ctx0_width, .ctx1_width, .ctx0_height, .ctx1_height, .hblank_clks, .vblank_clks,
    .mirror_h, .mirror_v, .row_skip, .col_skip, .bin_en, .test_pattern, .solid_value,
    .ae_enable, .ae_luma, .ae_target, .adc_data, .dout, .frame_valid, .line_valid,
    .pixel_clock_out, .out_oe, .col_addr, .row_addr, .analog_gain, .flash, .lane_en,
    .frame_count, .exposure_used);
  ifr_host_rx rx (.pclk(pixel_clock_out), .oe(out_oe), .fv(frame_valid), .lv(line_valid),
    .d(dout), .got(rx_got), .pix(rx_pix), .lines(rx_lines));

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_flash(input int lim);
    int n;
    n = 0;
    while (flash !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) check(16'h0, 16'h1);
  endtask
  // Exposure length is allowed a few control cycles either way around its nominal value.
  task automatic flash_len(input logic [15:0] e);
    int n;
    n = 0;
    while (flash === 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    check(16'(n >= (e + 1) * 200 - 8 && n <= (e + 1) * 200 + 8), 16'h1);
  endtask

  always @(negedge pixel_clock_out) begin
    if (rx_got === 1'b1) begin
      if (exp_q.size() == 0) check(16'hffff, 16'h0);
      else check(16'(rx_pix), 16'(exp_q.pop_front()));
    end
  end

  // A one-row window sits just below the optical centre, one row further when mirrored.
  always @(negedge link_clk) begin
    if (frame_valid === 1'b1 && !fv_was) begin
      check(16'(row_addr), 16'(`IFR_ACT_Y0 + `IFR_OPT_CY + 11'd1 + 11'(mirror_v)));
    end
    fv_was <= (frame_valid === 1'b1);
  end

  initial begin
    #500000;
    errors++;
    print_verdict();
  end

  initial begin
    int n;
    void'($urandom(32'h253c8427));
    ctx0_again = 2'($urandom_range(0, 3));
    ctx1_again = ~ctx0_again;
    ctx0_exposure = 16'($urandom_range(0, 1));
    ctx0_dgain = 9'($urandom_range(32, 256));
    ctx1_dgain = 9'($urandom_range(32, 256));
    ctx0_width = 11'($urandom_range(1, 3));
    solid_value = 12'($urandom());
    hblank_clks = 10'($urandom_range(0, 3));
    vblank_clks = 10'($urandom_range(0, 3));
    mirror_h = 1'($urandom());
    mirror_v = 1'($urandom());
    ae_luma = 12'($urandom());
    ae_target = 12'($urandom());
    wait_clk(4);
    rst = 1'b0;
    wait_flash(400);
    check(exposure_used, ctx0_exposure);
    check(16'(analog_gain), 16'(ctx0_again));
    for (int i = 0; i < ctx0_width; i++) exp_q.push_back(solid_value);
    trig_mode = 1'b1;
    flash_len(ctx0_exposure);
    n = 0;
    while (frame_count !== 16'h1 && n < 80000) begin
      @(negedge clk);
      n++;
    end
    check(frame_count, 16'h1);
    check(16'(exp_q.size()), 16'h0);
    check(rx_lines, 16'h1);
    check(16'(lane_en), 16'h0);
    $display("video frame test done");
    wait_clk(300);
    check(16'(flash), 16'h0);
    ctx_sel = 1'b1;
    trigger_in = 1'b1;
    wait_flash(40);
    trigger_in = 1'b0;
    check(16'(analog_gain), 16'(ctx1_again));
    check(exposure_used, ctx1_exposure);
    flash_len(ctx1_exposure);
    soft_reset_req = 1'b1;
    wait_clk(2);
    soft_reset_req = 1'b0;
    wait_clk(10);
    check(frame_count, 16'h0);
    check(exposure_used, 16'h0);
    $display("trigger and context test done");
    wait_clk(200);
    ctx_sel = 1'b0;
    trigger_in = 1'b1;
    wait_flash(40);
    trigger_in = 1'b0;
    wait_clk(20);
    reset_pin_n = 1'b0;
    wait_clk(8);
    check(16'(flash), 16'h0);
    check(16'(analog_gain), 16'h0);
    reset_pin_n = 1'b1;
    wait_clk(200);
    $display("reset pin test done");
    trig_mode = 1'b0;
    serial_sel = 1'b1;
    for (int i = 0; i < 2; i++) begin
      three_lanes = i[0];
      wait_clk(40);
      check(16'(lane_en), i ? 16'h7 : 16'h3);
    end
    serial_sel = 1'b0;
    output_enable_n = 1'b1;
    repeat (8) @(negedge link_clk);
    check(16'(out_oe), 16'h0);
    output_enable_n = 1'b0;
    repeat (8) @(negedge link_clk);
    check(16'(out_oe), 16'h1);
    $display("lanes and output enable test done");
    print_verdict();
  end
endmodule
`default_nettype wire
